// file: haptic_calibration_map.svh
`ifndef HAPTIC_CALIBRATION_MAP_SVH
`define HAPTIC_CALIBRATION_MAP_SVH

// ==========================================================
// Register offsets
`define FULL_SCALE_TARGET_OFFSET 8'h16
`define OVERDRIVE_LIMIT_OFFSET 8'h17
`define LOSS_COMPENSATION_OFFSET 8'h18
`define BACKEMF_CALIBRATION_OFFSET 8'h19
`define FEEDBACK_CONTROL_OFFSET 8'h1A

// ==========================================================
// Reset values
`define FULL_SCALE_TARGET_RESET 8'h3F
`define OVERDRIVE_LIMIT_RESET 8'h89
`define LOSS_COMPENSATION_RESET 8'h0D
`define BACKEMF_CALIBRATION_RESET 8'h6D
`define FEEDBACK_CONTROL_RESET 8'h36
`define UNMAPPED_READ_VALUE 8'h00

// ==========================================================
// Feedback control field positions
`define ACTUATOR_TYPE_BIT 7
`define BRAKE_RATIO_MSB 6
`define BRAKE_RATIO_LSB 4
`define LOOP_SPEED_MSB 3
`define LOOP_SPEED_LSB 2
`define BACKEMF_SCALE_MSB 1
`define BACKEMF_SCALE_LSB 0

// ==========================================================
// Scaling constants
`define COMPENSATION_FULL_SCALE 16'h00FF
`define BACKEMF_FULL_SCALE_MV 20'h004C4
`define BACKEMF_CODE_FULL_SCALE 20'h000FF
`define BACKEMF_DIVISOR_CODE0 20'h00001
`define BACKEMF_DIVISOR_CODE1 20'h00002
`define BACKEMF_DIVISOR_CODE2 20'h00004
`define BACKEMF_DIVISOR_CODE3 20'h00008

// ==========================================================
// Brake to drive gain ratios
`define BRAKE_RATIO_CODE0 5'h01
`define BRAKE_RATIO_CODE1 5'h02
`define BRAKE_RATIO_CODE2 5'h03
`define BRAKE_RATIO_CODE3 5'h04
`define BRAKE_RATIO_CODE4 5'h06
`define BRAKE_RATIO_CODE5 5'h08
`define BRAKE_RATIO_CODE6 5'h10
`define BRAKE_DISABLE_CODE 3'h7

`endif

// file: haptic_calibration_pkg.sv
package haptic_calibration_pkg;

  // ========================================================
  // Register port traffic
  typedef struct packed {
    logic strobe;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_type;

  // ========================================================
  // Auto-calibration results
  typedef struct packed {
    logic valid;
    logic [7:0] loss_compensation;
    logic [7:0] backemf_level;
  } cal_result_type;

  // ========================================================
  // Feedback control fields
  typedef struct packed {
    logic actuator_type_select;
    logic [2:0] brake_gain_ratio;
    logic [1:0] loop_speed;
    logic [1:0] backemf_scale_select;
  } feedback_control_type;

  // ========================================================
  // Serial port phases
  typedef enum logic [2:0] {
    phase_idle,
    phase_address,
    phase_pointer,
    phase_write_data,
    phase_read_data
  } serial_phase_type;

endpackage

// file: serial_register_port.sv
`timescale 1ns/1ps
module serial_register_port #(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h2C
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_drive_n,
  output haptic_calibration_pkg::reg_write_type reg_write,
  output logic [7:0] reg_pointer,
  input wire logic [7:0] read_data
);
  import haptic_calibration_pkg::*;

  // ========================================================
  // Pin synchronisers
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_prev;
  logic sda_prev;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  // ========================================================
  // Bus events
  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire start_seen = scl_s & scl_prev & sda_prev & ~sda_s;
  wire stop_seen = scl_s & scl_prev & ~sda_prev & sda_s;
  wire scl_rise = scl_s & ~scl_prev;
  wire scl_fall = ~scl_s & scl_prev;

  serial_phase_type phase;
  logic [3:0] bit_count;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic ack_slot;

  wire byte_done = scl_fall && !ack_slot && bit_count == 4'h8;
  wire ack_done = scl_fall && ack_slot;
  wire address_match = shift_in[7:1] == DEVICE_ADDRESS;

  // ========================================================
  // Byte engine
  // Pointer auto-increments so bursts walk the register map
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= phase_idle;
      bit_count <= 4'h0;
      shift_in <= 8'h00;
      shift_out <= 8'hFF;
      ack_slot <= 1'b0;
      sda_drive_n <= 1'b1;
      reg_write <= '0;
      reg_pointer <= 8'h00;
    end else begin
      reg_write.strobe <= 1'b0;
      if (start_seen) begin
        phase <= phase_address;
        bit_count <= 4'h0;
        ack_slot <= 1'b0;
        sda_drive_n <= 1'b1;
      end else if (stop_seen) begin
        phase <= phase_idle;
        ack_slot <= 1'b0;
        sda_drive_n <= 1'b1;
      end else if (phase != phase_idle && scl_rise) begin
        if (!ack_slot && bit_count != 4'h8) begin
          shift_in <= {shift_in[6:0], sda_s};
          bit_count <= bit_count + 4'h1;
        end else if (ack_slot && phase == phase_read_data && sda_s) begin
          // Host refused the byte: read burst ends here
          phase <= phase_idle;
        end
      end else if (phase != phase_idle && byte_done) begin
        ack_slot <= 1'b1;
        case (phase)
          phase_address: begin
            if (address_match) begin
              sda_drive_n <= 1'b0;
            end else begin
              phase <= phase_idle;
              ack_slot <= 1'b0;
            end
          end
          phase_pointer: begin
            reg_pointer <= shift_in;
            sda_drive_n <= 1'b0;
          end
          phase_write_data: begin
            reg_write.strobe <= 1'b1;
            reg_write.addr <= reg_pointer;
            reg_write.data <= shift_in;
            sda_drive_n <= 1'b0;
          end
          phase_read_data: begin
            reg_pointer <= reg_pointer + 8'h01;
            sda_drive_n <= 1'b1;
          end
          default: begin
            phase <= phase_idle;
          end
        endcase
      end else if (phase != phase_idle && ack_done) begin
        ack_slot <= 1'b0;
        bit_count <= 4'h0;
        sda_drive_n <= 1'b1;
        case (phase)
          phase_address: begin
            if (shift_in[0]) begin
              phase <= phase_read_data;
              shift_out <= read_data;
              sda_drive_n <= read_data[7];
            end else begin
              phase <= phase_pointer;
            end
          end
          phase_pointer: begin
            phase <= phase_write_data;
          end
          phase_write_data: begin
            reg_pointer <= reg_pointer + 8'h01;
          end
          phase_read_data: begin
            shift_out <= read_data;
            sda_drive_n <= read_data[7];
          end
          default: begin
            phase <= phase_idle;
          end
        endcase
      end else if (phase == phase_read_data && scl_fall && bit_count != 4'h0) begin
        shift_out <= {shift_out[6:0], 1'b1};
        sda_drive_n <= shift_out[6];
      end
    end
  end

endmodule // serial_register_port

// file: haptic_calibration_register_bank.sv
`timescale 1ns/1ps
`include "haptic_calibration_map.svh"

// Operation
// - Full-scale target is 8 bits, resets 0x3F, closed-loop reference, calibration input.
// - Open loop ignores full-scale target and uses overdrive limit instead.
// - Closed loop exceeds rated level only during overdrive and braking intervals.
// - Overdrive limit is 8 bits, resets 0x89, and clamps automatic overdrive.
// - Open loop uses the overdrive limit as its full-scale reference.
// - Loss compensation result is 8 bits, read/write, resets 0x0D, written by calibration.
// - Playback drive gain is multiplied by one plus compensation over 255.
// - Back-EMF result is 8 bits, read/write, resets 0x6D, written by calibration.
// - Back-EMF volts equal value over 255 times 1.22 V over gain setting.
// - Closed-loop feedback gain derives from the stored back-EMF result.
// - Feedback control at 0x1A: type, brake ratio, loop speed, back-EMF gain; reset 0x36.
// - Actuator type bit: 0 eccentric mass, 1 linear resonant; set before calibration.
// - Brake ratio codes 0 to 6 give 1,2,3,4,6,8,16x; code 7 disables braking.
module haptic_calibration_register_bank #(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h2C,
  parameter logic [15:0] FEEDBACK_GAIN_NUMERATOR = 16'h1000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_drive_n,
  input wire logic closed_loop,
  input wire logic overdrive_active,
  input wire logic braking_active,
  input wire logic [7:0] drive_request,
  input wire haptic_calibration_pkg::cal_result_type cal_result,
  output logic [7:0] full_scale_reference,
  output logic [7:0] calibration_target,
  output logic [7:0] drive_level,
  output logic [8:0] compensated_drive,
  output logic [11:0] backemf_millivolts,
  output logic [7:0] drive_feedback_gain,
  output logic [12:0] brake_feedback_gain,
  output logic brake_enable,
  output haptic_calibration_pkg::feedback_control_type feedback_fields
);
  import haptic_calibration_pkg::*;

  // ========================================================
  // Register port
  reg_write_type reg_write;
  logic [7:0] reg_pointer;
  logic [7:0] read_data;

  serial_register_port #(
    .DEVICE_ADDRESS(DEVICE_ADDRESS)
  ) port_inst (
    .clk(clk),
    .resetn(resetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_drive_n(sda_drive_n),
    .reg_write(reg_write),
    .reg_pointer(reg_pointer),
    .read_data(read_data)
  );

  // ========================================================
  // Storage
  logic [7:0] full_scale_target_level;
  logic [7:0] overdrive_limit;
  logic [7:0] loss_compensation_result;
  logic [7:0] backemf_calibration_result;
  logic [7:0] feedback_control;

  wire hit_target = reg_pointer == `FULL_SCALE_TARGET_OFFSET;
  wire hit_limit = reg_pointer == `OVERDRIVE_LIMIT_OFFSET;
  wire hit_loss = reg_pointer == `LOSS_COMPENSATION_OFFSET;
  wire hit_backemf = reg_pointer == `BACKEMF_CALIBRATION_OFFSET;
  wire hit_feedback = reg_pointer == `FEEDBACK_CONTROL_OFFSET;

  wire write_target = reg_write.strobe && reg_write.addr == `FULL_SCALE_TARGET_OFFSET;
  wire write_limit = reg_write.strobe && reg_write.addr == `OVERDRIVE_LIMIT_OFFSET;
  wire write_loss = reg_write.strobe && reg_write.addr == `LOSS_COMPENSATION_OFFSET;
  wire write_backemf = reg_write.strobe && reg_write.addr == `BACKEMF_CALIBRATION_OFFSET;
  wire write_feedback = reg_write.strobe && reg_write.addr == `FEEDBACK_CONTROL_OFFSET;

  // Unmapped pointers read zero and swallow writes
  assign read_data = hit_target ? full_scale_target_level :
                     hit_limit ? overdrive_limit :
                     hit_loss ? loss_compensation_result :
                     hit_backemf ? backemf_calibration_result :
                     hit_feedback ? feedback_control :
                     `UNMAPPED_READ_VALUE;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      full_scale_target_level <= `FULL_SCALE_TARGET_RESET;
      overdrive_limit <= `OVERDRIVE_LIMIT_RESET;
      feedback_control <= `FEEDBACK_CONTROL_RESET;
    end else begin
      if (write_target) begin
        full_scale_target_level <= reg_write.data;
      end
      if (write_limit) begin
        overdrive_limit <= reg_write.data;
      end
      if (write_feedback) begin
        feedback_control <= reg_write.data;
      end
    end
  end

  // Calibration result beats a host write landing in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loss_compensation_result <= `LOSS_COMPENSATION_RESET;
      backemf_calibration_result <= `BACKEMF_CALIBRATION_RESET;
    end else if (cal_result.valid) begin
      loss_compensation_result <= cal_result.loss_compensation;
      backemf_calibration_result <= cal_result.backemf_level;
    end else begin
      if (write_loss) begin
        loss_compensation_result <= reg_write.data;
      end
      if (write_backemf) begin
        backemf_calibration_result <= reg_write.data;
      end
    end
  end

  // ========================================================
  // Field split
  feedback_control_type fields;

  assign fields.actuator_type_select = feedback_control[`ACTUATOR_TYPE_BIT];
  assign fields.brake_gain_ratio = feedback_control[`BRAKE_RATIO_MSB:`BRAKE_RATIO_LSB];
  assign fields.loop_speed = feedback_control[`LOOP_SPEED_MSB:`LOOP_SPEED_LSB];
  assign fields.backemf_scale_select =
    feedback_control[`BACKEMF_SCALE_MSB:`BACKEMF_SCALE_LSB];

  // ========================================================
  // Reference and clamp
  wire [7:0] next_full_scale_reference =
    closed_loop ? full_scale_target_level : overdrive_limit;
  wire boost_interval = overdrive_active | braking_active;
  // Above the rated level only while overdrive or braking runs
  wire [7:0] level_ceiling =
    (closed_loop && boost_interval) ? overdrive_limit : next_full_scale_reference;
  wire [7:0] next_drive_level =
    (drive_request > level_ceiling) ? level_ceiling : drive_request;

  // ========================================================
  // Loss compensation
  // Exact divide by 255; costs a constant divider but avoids a gain bias
  wire [16:0] compensation_product =
    17'(next_drive_level) * (17'(`COMPENSATION_FULL_SCALE) + 17'(loss_compensation_result));
  wire [16:0] compensation_quotient =
    compensation_product / 17'(`COMPENSATION_FULL_SCALE);
  wire [8:0] next_compensated_drive = compensation_quotient[8:0];

  // ========================================================
  // Back-EMF scaling
  logic [19:0] backemf_divisor;

  always_comb begin
    case (fields.backemf_scale_select)
      2'h0: backemf_divisor = `BACKEMF_DIVISOR_CODE0;
      2'h1: backemf_divisor = `BACKEMF_DIVISOR_CODE1;
      2'h2: backemf_divisor = `BACKEMF_DIVISOR_CODE2;
      2'h3: backemf_divisor = `BACKEMF_DIVISOR_CODE3;
      default: backemf_divisor = `BACKEMF_DIVISOR_CODE0;
    endcase
  end

  wire [19:0] backemf_product = 20'(backemf_calibration_result) * `BACKEMF_FULL_SCALE_MV;
  wire [19:0] backemf_quotient =
    backemf_product / (`BACKEMF_CODE_FULL_SCALE * backemf_divisor);
  wire [11:0] next_backemf_millivolts = backemf_quotient[11:0];

  // ========================================================
  // Feedback gains
  // A zero back-EMF result is treated as one so the divide never faults
  wire [15:0] backemf_nonzero =
    (backemf_calibration_result == 8'h00) ? 16'h0001 : 16'(backemf_calibration_result);
  wire [15:0] gain_quotient = FEEDBACK_GAIN_NUMERATOR / backemf_nonzero;
  wire [7:0] next_drive_feedback_gain =
    (gain_quotient > 16'h00FF) ? 8'hFF : gain_quotient[7:0];

  logic [4:0] brake_ratio;

  always_comb begin
    case (fields.brake_gain_ratio)
      3'h0: brake_ratio = `BRAKE_RATIO_CODE0;
      3'h1: brake_ratio = `BRAKE_RATIO_CODE1;
      3'h2: brake_ratio = `BRAKE_RATIO_CODE2;
      3'h3: brake_ratio = `BRAKE_RATIO_CODE3;
      3'h4: brake_ratio = `BRAKE_RATIO_CODE4;
      3'h5: brake_ratio = `BRAKE_RATIO_CODE5;
      3'h6: brake_ratio = `BRAKE_RATIO_CODE6;
      default: brake_ratio = 5'h00;
    endcase
  end

  wire next_brake_enable = fields.brake_gain_ratio != `BRAKE_DISABLE_CODE;
  wire [12:0] next_brake_feedback_gain =
    13'(next_drive_feedback_gain) * 13'(brake_ratio);

  // ========================================================
  // Output registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      full_scale_reference <= 8'h00;
      calibration_target <= 8'h00;
      drive_level <= 8'h00;
      compensated_drive <= 9'h000;
    end else begin
      full_scale_reference <= next_full_scale_reference;
      calibration_target <= full_scale_target_level;
      drive_level <= next_drive_level;
      compensated_drive <= next_compensated_drive;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      backemf_millivolts <= 12'h000;
      drive_feedback_gain <= 8'h00;
      brake_feedback_gain <= 13'h0000;
      brake_enable <= 1'b0;
      feedback_fields <= '0;
    end else begin
      backemf_millivolts <= next_backemf_millivolts;
      drive_feedback_gain <= next_drive_feedback_gain;
      brake_feedback_gain <= next_brake_feedback_gain;
      brake_enable <= next_brake_enable;
      feedback_fields <= fields;
    end
  end

endmodule // haptic_calibration_register_bank

// file: haptic_calibration_register_bank_asserts.sv
`timescale 1ns/1ps
module haptic_calibration_asserts
  import haptic_calibration_pkg::*;
#(
  parameter logic [15:0] FEEDBACK_GAIN_NUMERATOR = 16'h1000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_drive_n,
  input wire logic closed_loop,
  input wire logic overdrive_active,
  input wire logic braking_active,
  input wire logic [7:0] drive_request,
  input wire haptic_calibration_pkg::cal_result_type cal_result,
  input wire logic [7:0] full_scale_reference,
  input wire logic [7:0] calibration_target,
  input wire logic [7:0] drive_level,
  input wire logic [8:0] compensated_drive,
  input wire logic [11:0] backemf_millivolts,
  input wire logic [7:0] drive_feedback_gain,
  input wire logic [12:0] brake_feedback_gain,
  input wire logic brake_enable,
  input wire haptic_calibration_pkg::feedback_control_type feedback_fields
);
  // ==========================================================
  // Reference tables
  function automatic logic [12:0] ratio_of(input logic [2:0] c);
    case (c)
      3'h4: return 13'h0006;
      3'h5: return 13'h0008;
      3'h6: return 13'h0010;
      3'h7: return 13'h0000;
      default: return 13'(c) + 13'h0001;
    endcase
  endfunction

  function automatic logic [7:0] gain_of(input logic [7:0] b);
    logic [15:0] q;
    q = FEEDBACK_GAIN_NUMERATOR / ((b == 8'h00) ? 16'h0001 : 16'(b));
    return (q > 16'h00FF) ? 8'hFF : q[7:0];
  endfunction

  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_ref_closed: assert property (
    closed_loop |=> full_scale_reference == calibration_target)
    else $error("closed-loop reference differs from target");
  a_drive_clamp: assert property (
    (!(closed_loop && (overdrive_active || braking_active)) && $stable(closed_loop))
    ##1 $stable(full_scale_reference) |-> drive_level == ((full_scale_reference <
    $past(drive_request)) ? full_scale_reference : $past(drive_request)))
    else $error("drive level not clamped to reference");
  a_comp_law: assert property (
    cal_result.valid ##1 !cal_result.valid |=> compensated_drive == 9'((17'(drive_level)
    * (17'h000FF + 17'($past(cal_result.loss_compensation, 2)))) / 17'h000FF))
    else $error("compensated drive wrong");
  a_bemf_volts: assert property (
    cal_result.valid ##1 !cal_result.valid |=> backemf_millivolts ==
    12'((20'($past(cal_result.backemf_level, 2)) * 20'h004C4) /
    (20'h000FF << feedback_fields.backemf_scale_select)))
    else $error("back-emf millivolts wrong");
  a_fb_gain: assert property (
    cal_result.valid ##1 !cal_result.valid |=>
    drive_feedback_gain == gain_of($past(cal_result.backemf_level, 2)))
    else $error("feedback gain not derived from back-emf result");
  a_brake_off: assert property (
    $past(resetn) |-> brake_enable == (feedback_fields.brake_gain_ratio != 3'h7))
    else $error("brake enable disagrees with ratio code");
  a_brake_ratio: assert property (
    $past(resetn) && $stable(feedback_fields) && $stable(drive_feedback_gain) |->
    brake_feedback_gain == 13'(drive_feedback_gain) * ratio_of(feedback_fields.brake_gain_ratio))
    else $error("brake gain ratio wrong");
  a_sda_low_only: assert property (
    $fell(sda_drive_n) |-> !scl_in)
    else $error("data line pulled while clock high");
endmodule // haptic_calibration_asserts

bind haptic_calibration_register_bank haptic_calibration_asserts #(
  .FEEDBACK_GAIN_NUMERATOR(FEEDBACK_GAIN_NUMERATOR)
) u_asserts (
  .clk(clk), .resetn(resetn), .scl_in(scl_in), .sda_drive_n(sda_drive_n),
  .closed_loop(closed_loop), .overdrive_active(overdrive_active),
  .braking_active(braking_active), .drive_request(drive_request), .cal_result(cal_result),
  .full_scale_reference(full_scale_reference), .calibration_target(calibration_target),
  .drive_level(drive_level), .compensated_drive(compensated_drive),
  .backemf_millivolts(backemf_millivolts), .drive_feedback_gain(drive_feedback_gain),
  .brake_feedback_gain(brake_feedback_gain), .brake_enable(brake_enable),
  .feedback_fields(feedback_fields)
);

// file: serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model #(
  parameter int HALF = 10
) (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_drive_n
);
  // ==========================================================
  // Bus idles released; half period well above the sync delay
  initial begin
    scl_out = 1'b1;
    sda_drive_n = 1'b1;
  end

  task automatic half;
    repeat (HALF) @(negedge clk);
  endtask

  task automatic start;
    sda_drive_n = 1'b1;
    half;
    scl_out = 1'b1;
    half;
    sda_drive_n = 1'b0;
    half;
    scl_out = 1'b0;
  endtask

  task automatic stop;
    sda_drive_n = 1'b0;
    half;
    scl_out = 1'b1;
    half;
    sda_drive_n = 1'b1;
    half;
  endtask

  // Bit sampled at end of high phase, after the device settles
  task automatic clock_bit(input logic b, output logic s);
    sda_drive_n = b;
    half;
    scl_out = 1'b1;
    half;
    s = sda_in;
    scl_out = 1'b0;
  endtask

  task automatic byte_xfer(input logic [7:0] b, output logic [7:0] s, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], s[i]);
    end
    clock_bit(1'b1, n);
    ack = !n;
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
                           output logic ack);
    logic [7:0] s;
    logic a0, a1, a2;
    start;
    byte_xfer({dev, 1'b0}, s, a0);
    byte_xfer(p, s, a1);
    byte_xfer(d, s, a2);
    stop;
    ack = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] d);
    logic [7:0] s;
    logic a, n;
    start;
    byte_xfer({dev, 1'b0}, s, a);
    byte_xfer(p, s, a);
    start;
    byte_xfer({dev, 1'b1}, s, a);
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, d[i]);
    end
    clock_bit(1'b1, n);
    stop;
  endtask
endmodule // serial_host_model

// file: haptic_calibration_register_bank_tb_top.sv
`timescale 1ns/1ps
module haptic_calibration_register_bank_tb_top;
  import haptic_calibration_pkg::*;
  localparam logic [6:0] DEV = 7'h2C;
  typedef struct packed {
    logic cl, od, br;
    logic [7:0] req, lvl, fsr;
  } row_type;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic scl, host_sda_n, dev_sda_n, closed_loop, overdrive_active, braking_active, ack;
  logic [7:0] drive_request, full_scale_reference, calibration_target, drive_level, rd;
  logic [7:0] drive_feedback_gain;
  logic [8:0] compensated_drive;
  logic [11:0] backemf_millivolts;
  logic [12:0] brake_feedback_gain;
  logic brake_enable;
  cal_result_type cal_result;
  feedback_control_type feedback_fields;
  int bad_count = 0;
  int n_compared = 0;
  // Pull-up: a released line reads high
  wire sda = host_sda_n & dev_sda_n;
  logic [7:0] dflt [5] = '{8'h3F, 8'h89, 8'h0D, 8'h6D, 8'h36};
  logic [12:0] ratio [8] = '{13'h1, 13'h2, 13'h3, 13'h4, 13'h6, 13'h8, 13'h10, 13'h0};
  row_type rows [8] = '{
    '{1'b1, 1'b0, 1'b0, 8'h20, 8'h20, 8'h3F}, '{1'b1, 1'b0, 1'b0, 8'hF0, 8'h3F, 8'h3F},
    '{1'b1, 1'b1, 1'b0, 8'hF0, 8'h89, 8'h3F}, '{1'b1, 1'b0, 1'b1, 8'hF0, 8'h89, 8'h3F},
    '{1'b1, 1'b1, 1'b1, 8'h50, 8'h50, 8'h3F}, '{1'b0, 1'b0, 1'b0, 8'hF0, 8'h89, 8'h89},
    '{1'b0, 1'b1, 1'b0, 8'hF0, 8'h89, 8'h89}, '{1'b0, 1'b0, 1'b0, 8'h40, 8'h40, 8'h89}};

  always #2 clk = ~clk;

  haptic_calibration_register_bank uut (
    .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_drive_n(dev_sda_n),
    .closed_loop(closed_loop), .overdrive_active(overdrive_active),
    .braking_active(braking_active), .drive_request(drive_request), .cal_result(cal_result),
    .full_scale_reference(full_scale_reference), .calibration_target(calibration_target),
    .drive_level(drive_level), .compensated_drive(compensated_drive),
    .backemf_millivolts(backemf_millivolts), .drive_feedback_gain(drive_feedback_gain),
    .brake_feedback_gain(brake_feedback_gain), .brake_enable(brake_enable),
    .feedback_fields(feedback_fields)
  );
  serial_host_model host (.clk(clk), .sda_in(sda), .scl_out(scl), .sda_drive_n(host_sda_n));

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host.write_reg(DEV, p, d, ack);
    check(16'(ack), 16'h0001);
  endtask

  task automatic rd_chk(input logic [7:0] p, input logic [7:0] exp);
    host.read_reg(DEV, p, rd);
    check(16'(rd), 16'(exp));
  endtask

  task automatic drive(input row_type r);
    {closed_loop, overdrive_active, braking_active, drive_request} = {r.cl, r.od, r.br, r.req};
    repeat (4) @(negedge clk);
  endtask

  initial begin
    {closed_loop, overdrive_active, braking_active, drive_request} = 11'h000;
    cal_result = '0;
    repeat (8) @(negedge clk);
    check(16'(dev_sda_n), 16'h0001);
    check(16'(drive_level), 16'h0000);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    check(16'(feedback_fields), 16'h0036);
    check(16'(brake_enable), 16'h0001);
    check(16'(backemf_millivolts), 16'h0082);
    check(16'(drive_feedback_gain), 16'h0025);
    for (int i = 0; i < 5; i++) rd_chk(8'h16 + 8'(i), dflt[i]);
    foreach (rows[i]) begin
      drive(rows[i]);
      check(16'(drive_level), 16'(rows[i].lvl));
      check(16'(full_scale_reference), 16'(rows[i].fsr));
      check(16'(compensated_drive), (16'(rows[i].lvl) * 16'h010C) / 16'h00FF);
    end
    // ========================================================
    // Awkward cases
    host.write_reg(DEV ^ 7'h01, 8'h17, 8'h11, ack);
    check(16'(ack), 16'h0000);
    wr(8'h17, 8'h60);
    rd_chk(8'h17, 8'h60);
    drive('{1'b0, 1'b0, 1'b0, 8'hF0, 8'h00, 8'h00});
    check(16'(drive_level), 16'h0060);
    drive('{1'b1, 1'b1, 1'b0, 8'hF0, 8'h00, 8'h00});
    check(16'(drive_level), 16'h0060);
    wr(8'h20, 8'h55);
    rd_chk(8'h20, 8'h00);
    wr(8'h16, 8'h50);
    rd_chk(8'h16, 8'h50);
    check(16'(calibration_target), 16'h0050);
    for (int c = 0; c < 8; c++) begin
      wr(8'h1A, {1'b1, 3'(c), 4'h1});
      check(16'(feedback_fields), 16'({1'b1, 3'(c), 4'h1}));
      check(16'(brake_enable), 16'(c != 7));
      check(16'(brake_feedback_gain), 16'(13'h0025 * ratio[c]));
    end
    drive('{1'b1, 1'b0, 1'b0, 8'hF0, 8'h00, 8'h00});
    cal_result = '{1'b1, 8'h40, 8'h20};
    @(negedge clk);
    cal_result.valid = 1'b0;
    repeat (3) @(negedge clk);
    check(16'(drive_level), 16'h0050);
    check(16'(compensated_drive), 16'h0064);
    check(16'(backemf_millivolts), 16'h004C);
    check(16'(drive_feedback_gain), 16'h0080);
    rd_chk(8'h18, 8'h40);
    rd_chk(8'h19, 8'h20);
    wr(8'h19, 8'h00);
    check(16'(drive_feedback_gain), 16'h00FF);
    resetn = 1'b0;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    rd_chk(8'h16, 8'h3F);
    rd_chk(8'h19, 8'h6D);
    cal_result = '{1'b1, 8'hFF, 8'h6D};
    @(negedge clk);
    cal_result.valid = 1'b0;
    drive(rows[5]);
    check(16'(compensated_drive), 16'h0112);
    end_sim;
  end

  // Run needs about 70 us; the margin covers a stalled bus
  initial begin
    #300000;
    bad_count++;
    end_sim;
  end
endmodule // haptic_calibration_register_bank_tb_top
